//--- hdl/adc_clock_and_sample_sequencer.sv
// Top of the converter clock and sample/hold sequencer with its register port.
`timescale 1ns/1ns
`default_nettype none
module adc_clock_and_sample_sequencer (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire adc_seq_pkg::reg_req_t reg_req_in,
    output logic [adc_seq_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic rc_osc_in,
    input wire logic [adc_seq_pkg::RES_W-1:0] conv_result_in,
    output adc_seq_pkg::analog_ctrl_t analog_ctrl_out,
    output logic module_power_out,
    output logic done_out
);
    import adc_seq_pkg::*;

    // ========================================
    // State machine
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DISCHARGE = 2'b01,
        ST_SAMPLE = 2'b11,
        ST_CONVERT = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [DATA_W-1:0] ctrl_one;
        logic [DATA_W-1:0] ctrl_two;
        logic [DATA_W-1:0] ctrl_three;
        logic [DATA_W-1:0] input_sel;
        seq_state_t state;
        logic [4:0] tad_count;
        logic [1:0] sample_ch;
        logic [1:0] conv_ch;
        logic [1:0] conv_left;
        logic [SMPI_W-1:0] smp_count;
        logic [CH_W-1:0] wr_ptr;
        logic [CH_W-1:0] raddr;
        logic rd_result;
        logic rd_pending;
        logic [DATA_W-1:0] rdata;
        logic done;
        logic [RES_W-1:0] last_result;
        analog_ctrl_t actl;
    } top_state_t;

    top_state_t cur;
    top_state_t next_cur;
    logic tick;
    logic [RES_W-1:0] store_rdata;
    logic store_we;

    // Number of enabled channels minus one, decoded in several places.
    function automatic logic [1:0] chan_last(input logic [1:0] cnt_sel);
        unique case (cnt_sel)
            2'b00: chan_last = 2'd0;
            2'b01: chan_last = 2'd1;
            default: chan_last = 2'd3;
        endcase
    endfunction

    function automatic logic [CH_W-1:0] ch_bit(input logic [1:0] ch);
        ch_bit = CH_W'(1) << ch;
    endfunction

    // Mask of the enabled channels, so simultaneous sampling never wakes an unused one.
    function automatic logic [CH_W-1:0] chan_mask(input logic [1:0] cnt_sel);
        unique case (cnt_sel)
            2'b00: chan_mask = 4'h1;
            2'b01: chan_mask = 4'h3;
            default: chan_mask = 4'hf;
        endcase
    endfunction

    // ========================================
    // Fields
    logic module_on;
    logic [2:0] trig_sel;
    logic simultaneous_sample_select;
    logic auto_sample;
    logic sample_ctrl;
    logic [1:0] chan_sel;
    logic [SMPI_W-1:0] smpi;
    logic [SAMC_W-1:0] samc;
    logic rc_sel;
    logic [DIV_W-1:0] divider;
    logic rst_n;

    assign rst_n = cur.rst_sync[1];
    assign module_on = cur.ctrl_one[POS_MODULE_ON];
    assign trig_sel = cur.ctrl_one[POS_TRIG_LO +: 3];
    assign simultaneous_sample_select = cur.ctrl_one[POS_SIMULTANEOUS_SAMPLE_SELECT];
    assign auto_sample = cur.ctrl_one[POS_AUTO_SAMPLE];
    assign sample_ctrl = cur.ctrl_one[POS_SAMPLE_CTRL];
    assign chan_sel = cur.ctrl_two[POS_CHCNT_LO +: 2];
    assign smpi = cur.ctrl_two[POS_SMPI_LO +: SMPI_W];
    assign samc = cur.ctrl_three[POS_SAMC_LO +: SAMC_W];
    assign rc_sel = cur.ctrl_three[POS_RC_SEL];
    assign divider = cur.ctrl_three[DIV_W-1:0];

    conv_clock_gen u_clk (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .run_in(module_on),
        .divider_in(divider),
        .rc_select_in(rc_sel),
        .rc_osc_in(rc_osc_in),
        .tick_out(tick)
    );

    // Results are written only when a conversion finishes, never on abort.
    assign store_we = tick && cur.state == ST_CONVERT && cur.tad_count == 5'd1 && module_on;

    result_store u_store (
        .core_clk_in(core_clk_in),
        .we_in(store_we),
        .waddr_in(cur.wr_ptr),
        .wdata_in(conv_result_in),
        .raddr_in(cur.raddr),
        .rdata_out(store_rdata)
    );

    // ========================================
    // Next state
    always_comb begin
        next_cur = cur;
        next_cur.rst_sync = {cur.rst_sync[0], 1'b1};
        next_cur.done = 1'b0;
        next_cur.rd_result = 1'b0;
        next_cur.rd_pending = 1'b0;
        next_cur.actl.hold_discharge = '0;

        // Register port: reads answer one cycle later.
        if (reg_req_in.wr) begin
            unique case (reg_req_in.addr)
                OFS_CTRL_ONE: next_cur.ctrl_one = reg_req_in.wdata;
                OFS_CTRL_TWO: next_cur.ctrl_two = reg_req_in.wdata;
                OFS_CTRL_THREE: next_cur.ctrl_three = reg_req_in.wdata;
                OFS_INPUT_SEL: next_cur.input_sel = reg_req_in.wdata;
                default: ;
            endcase
        end
        if (reg_req_in.rd) begin
            unique case (reg_req_in.addr)
                OFS_CTRL_ONE: next_cur.rdata = cur.ctrl_one;
                OFS_CTRL_TWO: next_cur.rdata = cur.ctrl_two;
                OFS_CTRL_THREE: next_cur.rdata = cur.ctrl_three;
                OFS_INPUT_SEL: next_cur.rdata = cur.input_sel;
                OFS_STATUS: next_cur.rdata = {cur.state, cur.conv_ch, cur.sample_ch, cur.wr_ptr, 6'h00};
                OFS_RESULT: next_cur.rdata = {6'h00, cur.last_result};
                default: next_cur.rdata = READ_ZERO;
            endcase
        end
        next_cur.actl.mux_select = cur.input_sel;

        if (!module_on) begin
            // Off: every sequence stops, channels idle, results untouched.
            next_cur.state = ST_IDLE;
            next_cur.actl.sample_en = '0;
            next_cur.actl.convert_active = 1'b0;
            next_cur.actl.convert_channel = 2'd0;
            next_cur.conv_ch = 2'd0;
            next_cur.smp_count = '0;
            next_cur.wr_ptr = '0;
            next_cur.sample_ch = 2'd0;
        end else if (tick) begin
            unique case (cur.state)
                ST_IDLE: begin
                    if (sample_ctrl || auto_sample) begin
                        next_cur.state = ST_DISCHARGE;
                    end
                end
                ST_DISCHARGE: begin
                    // Capacitor is drained for one period before any sample.
                    next_cur.actl.sample_en = simultaneous_sample_select ? chan_mask(chan_sel) : ch_bit(cur.sample_ch);
                    next_cur.tad_count = (samc == '0) ? 5'd1 : samc;
                    next_cur.state = ST_SAMPLE;
                end
                ST_SAMPLE: begin
                    if (cur.tad_count != '0) begin
                        next_cur.tad_count = cur.tad_count - 5'd1;
                    end
                    if ((trig_sel == TRIG_AUTO && cur.tad_count <= 5'd1)
                        || (trig_sel == TRIG_SOFTWARE && !sample_ctrl)) begin
                        // Hold the sample, begin the twelve-period conversion.
                        next_cur.actl.sample_en = '0;
                        next_cur.conv_ch = simultaneous_sample_select ? 2'd0 : cur.sample_ch;
                        next_cur.conv_left = simultaneous_sample_select ? chan_last(chan_sel) : 2'd0;
                        next_cur.actl.convert_channel = simultaneous_sample_select ? 2'd0 : cur.sample_ch;
                        next_cur.actl.convert_active = 1'b1;
                        next_cur.tad_count = CONV_PERIODS;
                        next_cur.state = ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    next_cur.tad_count = cur.tad_count - 5'd1;
                    // Next channel acquires while this one converts.
                    if (!simultaneous_sample_select && chan_sel != 2'b00 && cur.tad_count == CONV_PERIODS) begin
                        next_cur.actl.sample_en = ch_bit(cur.sample_ch + 2'd1 & chan_last(chan_sel));
                    end
                    if (cur.tad_count == 5'd1) begin
                        next_cur.raddr = cur.wr_ptr;
                        next_cur.rd_result = 1'b1;
                        next_cur.wr_ptr = cur.wr_ptr + 4'd1;
                        if (cur.smp_count == smpi) begin
                            next_cur.smp_count = '0;
                            next_cur.wr_ptr = '0;
                            next_cur.done = 1'b1;
                        end else begin
                            next_cur.smp_count = cur.smp_count + 4'd1;
                        end
                        if (cur.conv_left != 2'd0) begin
                            next_cur.conv_left = cur.conv_left - 2'd1;
                            next_cur.conv_ch = cur.conv_ch + 2'd1;
                            next_cur.actl.convert_channel = cur.conv_ch + 2'd1;
                            next_cur.tad_count = CONV_PERIODS;
                        end else begin
                            next_cur.actl.convert_active = 1'b0;
                            // Channels rotate so the total rate is shared.
                            next_cur.sample_ch = (cur.sample_ch + 2'd1) & chan_last(chan_sel);
                            next_cur.state = ST_IDLE;
                            if (auto_sample && !simultaneous_sample_select && chan_sel != 2'b00) begin
                                // The next channel has sampled since the second period; keep that sample.
                                next_cur.tad_count = (samc == '0) ? 5'd1 : samc;
                                next_cur.state = ST_SAMPLE;
                            end else if (auto_sample) begin
                                next_cur.state = ST_DISCHARGE;
                            end else begin
                                next_cur.actl.sample_en = '0;
                                // A software write in the same cycle wins over this clear.
                                if (!(reg_req_in.wr && reg_req_in.addr == OFS_CTRL_ONE)) begin
                                    next_cur.ctrl_one[POS_SAMPLE_CTRL] = 1'b0;
                                end
                            end
                        end
                    end
                end
                default: next_cur.state = ST_IDLE;
            endcase
        end

        // The finished word is read back from the buffer, so the copy always matches it.
        next_cur.rd_pending = cur.rd_result;
        if (cur.rd_pending) begin
            next_cur.last_result = store_rdata;
        end
        next_cur.actl.hold_discharge = '0;
        if (next_cur.state == ST_DISCHARGE) begin
            next_cur.actl.hold_discharge = simultaneous_sample_select ? chan_mask(chan_sel) : ch_bit(next_cur.sample_ch);
        end else if (next_cur.state == ST_CONVERT && next_cur.tad_count == CONV_PERIODS && !simultaneous_sample_select
            && chan_sel != 2'b00) begin
            // Drained during the first period, before the overlapped sample starts.
            next_cur.actl.hold_discharge = ch_bit((next_cur.sample_ch + 2'd1) & chan_last(chan_sel));
        end
        if (!rst_n) begin
            // State stays clear until the second reset stage lets go.
            next_cur = '0;
            next_cur.rst_sync = {cur.rst_sync[0], 1'b1};
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata_out = cur.rdata;
    assign analog_ctrl_out = cur.actl;
    assign module_power_out = cur.ctrl_one[POS_MODULE_ON];
    assign done_out = cur.done;
endmodule
`default_nettype wire

//--- hdl/adc_seq_pkg.sv
// Package with constants and types for the converter clock and sample sequencer.
package adc_seq_pkg;
    // ========================================
    // Field widths
    localparam int DIV_W = 6;
    localparam int SAMC_W = 5;
    localparam int SMPI_W = 4;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int RES_W = 10;
    localparam int CH_W = 4;
    // ========================================
    // Register offsets
    localparam logic [3:0] OFS_CTRL_ONE = 4'h0;
    localparam logic [3:0] OFS_CTRL_TWO = 4'h1;
    localparam logic [3:0] OFS_CTRL_THREE = 4'h2;
    localparam logic [3:0] OFS_INPUT_SEL = 4'h3;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_RESULT = 4'h5;
    // ========================================
    // Field positions
    localparam int POS_MODULE_ON = 15;
    localparam int POS_TRIG_LO = 5;
    localparam int POS_SIMULTANEOUS_SAMPLE_SELECT = 3;
    localparam int POS_AUTO_SAMPLE = 2;
    localparam int POS_SAMPLE_CTRL = 1;
    localparam int POS_CHCNT_LO = 8;
    localparam int POS_SMPI_LO = 2;
    localparam int POS_SAMC_LO = 8;
    localparam int POS_RC_SEL = 7;
    // ========================================
    // Encodings and timing counts
    localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    localparam logic [4:0] CONV_PERIODS = 5'h0c;
    localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
    localparam logic [DIV_W:0] HALF_CYCLE_ONE = 7'h01;

    // ========================================
    // Carriers
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [CH_W-1:0] sample_en;
        logic [CH_W-1:0] hold_discharge;
        logic [1:0] convert_channel;
        logic convert_active;
        logic [DATA_W-1:0] mux_select;
    } analog_ctrl_t;
endpackage

//--- hdl/conv_clock_gen.sv
// Conversion clock enable generator from the instruction clock or the RC oscillator.
`timescale 1ns/1ns
`default_nettype none
module conv_clock_gen (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    input wire logic [adc_seq_pkg::DIV_W-1:0] divider_in,
    input wire logic rc_select_in,
    input wire logic rc_osc_in,
    output logic tick_out
);
    import adc_seq_pkg::*;

    typedef struct packed {
        logic [DIV_W:0] count;
        logic [2:0] rc_sync;
        logic tick;
    } gen_state_t;

    gen_state_t cur;
    gen_state_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        next_cur.rc_sync = {cur.rc_sync[1:0], rc_osc_in};
        if (!run_in) begin
            next_cur.count = '0;
        end else if (rc_select_in) begin
            // A rising RC edge counts when the middle stage is high and the last stage is still low.
            if (cur.rc_sync[2:1] == 2'b01) begin
                next_cur.tick = 1'b1;
            end
        end else if (cur.count == '0) begin
            // Half instruction cycles: the core clock stands for half a cycle.
            next_cur.count = {1'b0, divider_in};
            next_cur.tick = 1'b1;
        end else begin
            next_cur.count = cur.count - HALF_CYCLE_ONE;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tick_out = cur.tick;
endmodule
`default_nettype wire

//--- hdl/result_store.sv
// Small result memory with a registered read port.
`timescale 1ns/1ns
`default_nettype none
module result_store (
    input wire logic core_clk_in,
    input wire logic we_in,
    input wire logic [adc_seq_pkg::CH_W-1:0] waddr_in,
    input wire logic [adc_seq_pkg::RES_W-1:0] wdata_in,
    input wire logic [adc_seq_pkg::CH_W-1:0] raddr_in,
    output logic [adc_seq_pkg::RES_W-1:0] rdata_out
);
    import adc_seq_pkg::*;

    logic [RES_W-1:0] mem [16];

    // Contents survive reset, so no reset term is given.
    always_ff @(posedge core_clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        rdata_out <= mem[raddr_in];
    end
endmodule
`default_nettype wire

//--- verification/analog_front_model.sv
// Behavioural analog multiplexer and sample/hold channels feeding the converter result.
`timescale 1ns/1ns
`default_nettype none
module analog_front_model (
    input wire logic clk_in,
    input wire adc_seq_pkg::analog_ctrl_t ctrl_in,
    output logic [adc_seq_pkg::RES_W-1:0] result_out
);
    import adc_seq_pkg::*;
    logic [RES_W-1:0] last = 10'h000;
    // Outside a conversion the lines carry the inverse of the last value, so a late capture is caught.
    always_comb begin
        if (ctrl_in.convert_active) begin
            result_out = ctrl_in.mux_select[RES_W-1:0] ^ {8'h00, ctrl_in.convert_channel};
        end else begin
            result_out = ~last;
        end
    end
    always_ff @(posedge clk_in) begin
        if (ctrl_in.convert_active) begin
            last <= result_out;
        end
    end
endmodule
`default_nettype wire

//--- verification/adc_clock_and_sample_sequencer_asserts.sv
// Checker for the converter clock and sample sequencer ports.
`timescale 1ns/1ns
`default_nettype none
module adc_seq_checker (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire adc_seq_pkg::reg_req_t reg_req_in,
    input wire adc_seq_pkg::analog_ctrl_t analog_ctrl_out,
    input wire logic module_power_out,
    input wire logic done_out
);
    import adc_seq_pkg::*;
    logic [15:0] conv_cnt;
    logic [1:0] chcnt;
    logic simultaneous_sample_select;
    // ========================================
    // Conversion length count, and shadow of the mode fields taken from the register writes.
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            conv_cnt <= 16'h0000;
            chcnt <= 2'b00;
            simultaneous_sample_select <= 1'b0;
        end else begin
            conv_cnt <= analog_ctrl_out.convert_active ? conv_cnt + 16'h0001 : 16'h0000;
            if (reg_req_in.wr && reg_req_in.addr == OFS_CTRL_TWO) begin
                chcnt <= reg_req_in.wdata[POS_CHCNT_LO +: 2];
            end
            if (reg_req_in.wr && reg_req_in.addr == OFS_CTRL_ONE) begin
                simultaneous_sample_select <= reg_req_in.wdata[POS_SIMULTANEOUS_SAMPLE_SELECT];
            end
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    // ========================================
    // Properties.
    a_conv_min_len: assert property (
        $fell(analog_ctrl_out.convert_active) && module_power_out |-> conv_cnt >= CONV_PERIODS)
        else $error("conversion shorter than twelve periods");
    a_power_follows: assert property (
        reg_req_in.wr && reg_req_in.addr == OFS_CTRL_ONE |=> module_power_out == $past(reg_req_in.wdata[POS_MODULE_ON]))
        else $error("module on output does not follow its bit");
    a_off_idle: assert property (
        !module_power_out && !$past(module_power_out) |-> !analog_ctrl_out.convert_active
        && analog_ctrl_out.sample_en == 4'h0) else $error("activity while the module is off");
    a_abort_stops: assert property (
        $fell(module_power_out) |-> ##[0:1] !analog_ctrl_out.convert_active)
        else $error("conversion not aborted");
    a_single_channel: assert property (
        chcnt == 2'b00 |-> analog_ctrl_out.convert_channel == 2'b00 && analog_ctrl_out.sample_en[3:1] == 3'h0)
        else $error("extra channel used with one channel selected");
    a_seq_sample: assert property (
        !simultaneous_sample_select |-> $countones(analog_ctrl_out.sample_en) <= 1) else $error("channels sampled together");
    a_discharge_first: assert property (
        $rose(analog_ctrl_out.sample_en[0]) |-> $past(analog_ctrl_out.hold_discharge[0]))
        else $error("sample started without discharge");
    a_done_pulse: assert property (done_out |=> !done_out) else $error("done longer than one cycle");
    c_overlap: cover property (analog_ctrl_out.convert_active && analog_ctrl_out.sample_en[1]);
endmodule
bind adc_clock_and_sample_sequencer adc_seq_checker i_checker (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .reg_req_in(reg_req_in), .analog_ctrl_out(analog_ctrl_out), .module_power_out(module_power_out),
    .done_out(done_out));
`default_nettype wire

//--- verification/adc_clock_and_sample_sequencer_test.sv
// Self-checking bench for the converter clock and sample sequencer.
`timescale 1ns/1ns
`default_nettype none
module adc_clock_and_sample_sequencer_test;
    import adc_seq_pkg::*;
    logic clk, resetn, rc, power, done, ov;
    reg_req_t req;
    logic [DATA_W-1:0] rdata, d, n, dv, samc, sel, three;
    logic [RES_W-1:0] res;
    analog_ctrl_t actl;
    logic [7:0] seed = 8'h1a;
    logic [15:0] divs[4] = '{16'h0014, 16'h0015, 16'h003f, 16'h0014};
    int failures = 0;
    int comparisons = 0;
    int cyc[4];
    adc_clock_and_sample_sequencer i_dut (.core_clk_in(clk), .resetn_in(resetn), .reg_req_in(req),
        .reg_rdata_out(rdata), .rc_osc_in(rc), .conv_result_in(res), .analog_ctrl_out(actl),
        .module_power_out(power), .done_out(done));
    analog_front_model i_front (.clk_in(clk), .ctrl_in(actl), .result_out(res));
    initial begin clk = 1'b0; forever #2 clk = ~clk; end
    // The RC source is left unrelated in phase to the core clock.
    initial begin rc = 1'b0; #1; forever #48 rc = ~rc; end
    // ========================================
    // Helpers.
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic pick(input int s);
        return s == 0 ? actl.sample_en[0] : actl.convert_active;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk); req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk); req <= '0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk); req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk); req <= '0;
        #1 v = rdata;
    endtask
    // Counts the cycles of the next high stretch; the bound stops a stuck sequencer.
    task automatic span(input int s, output logic [15:0] c);
        int i;
        c = 16'h0000; i = 0; #1;
        while (!pick(s) && i < 9000) begin @(posedge clk); #1; i++; end
        while (pick(s) && i < 9000) begin @(posedge clk); #1; c++; i++; end
    endtask
    task automatic done_gap(output logic [15:0] c);
        int i;
        logic p;
        c = 16'h0000; i = 0;
        while (done !== 1'b1 && i < 9000) begin @(posedge clk); #1; i++; end
        @(posedge clk); #1; p = actl.convert_active;
        while (done !== 1'b1 && i < 9000) begin
            @(posedge clk); #1; i++;
            if (p && !actl.convert_active) c++;
            p = actl.convert_active;
        end
    endtask
    task automatic cfg(input logic [15:0] one, input logic [15:0] two, input logic [15:0] thr, input logic [15:0] s);
        wr(OFS_CTRL_ONE, RESET_WORD);
        wr(OFS_CTRL_THREE, thr);
        wr(OFS_CTRL_TWO, two);
        wr(OFS_INPUT_SEL, s);
        wr(OFS_CTRL_ONE, one);
        repeat (8) @(posedge clk);
    endtask
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin repeat (90000) @(posedge clk); failures++; conclude(); end
    // ========================================
    // Main sequence.
    initial begin
        resetn = 1'b0; req = '0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 0; a < 4; a++) begin rd(a[3:0], d); chk("reset_value", d, RESET_WORD); end
        rd(4'hf, d); chk("unmapped", d, READ_ZERO);
        chk("reset_power", power, 1'b0);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            dv = (k == 3) ? 16'h0014 + {13'h0000, seed[2:0]} : divs[k];
            samc = (k == 1) ? 16'h0002 : {13'h0000, seed[5:3]} + 16'h0001;
            sel = {seed, lfsr(seed)};
            three = (samc << 8) | dv;
            cfg(16'h80e4, {12'h000, seed[7:6], 2'b00}, three, sel);
            rd(OFS_CTRL_THREE, d); chk("ctrl_three", d, three);
            span(0, n); chk("sample_len", n, samc * (dv + 16'h0001));
            span(1, n); chk("conv_len", n, 16'h000c * (dv + 16'h0001));
            span(0, n); chk("resample_len", n, samc * (dv + 16'h0001));
            done_gap(n); chk("conv_per_done", n, {14'h0000, seed[7:6]} + 16'h0001);
            rd(OFS_RESULT, d); chk("result", d, {6'h00, sel[9:0]});
        end
        cfg(16'h8000, 16'h0000, 16'h0114, 16'h0155);
        wr(OFS_CTRL_ONE, 16'h8002);
        repeat (60) @(posedge clk);
        #1 chk("manual_hold", {actl.sample_en[0], actl.convert_active}, 2'b10);
        wr(OFS_CTRL_ONE, 16'h8000);
        span(1, n); chk("manual_conv", n, 16'h00fc);
        rd(OFS_CTRL_ONE, d); chk("sample_bit", d, 16'h8000);
        rd(OFS_RESULT, d); chk("manual_result", d, 16'h0155);
        wr(OFS_INPUT_SEL, 16'h02aa);
        wr(OFS_CTRL_ONE, 16'h8002);
        repeat (40) @(posedge clk);
        wr(OFS_CTRL_ONE, 16'h8000);
        repeat (60) @(posedge clk);
        #1 chk("abort_busy", actl.convert_active, 1'b1);
        wr(OFS_CTRL_ONE, RESET_WORD);
        repeat (3) @(posedge clk);
        #1 chk("abort", {power, actl.convert_active, done}, 3'b000);
        rd(OFS_RESULT, d); chk("abort_result", d, 16'h0155);
        cfg(16'h80e4, 16'h0000, 16'h0180, 16'h0001);
        span(1, n); chk("rc_conv", n, 16'h0120);
        // Two channels share one input, sequential sampling, two conversions per done.
        cfg(16'h80e4, 16'h0104, 16'h0214, 16'h0003);
        ov = 1'b0; cyc = '{0, 0, 0, 0};
        repeat (3000) begin
            @(posedge clk); #1;
            if (actl.convert_active) cyc[actl.convert_channel]++;
            if (actl.convert_active && actl.sample_en != 4'h0) ov = 1'b1;
        end
        chk("overlap", ov, 1'b1);
        chk("share", cyc[1] > 0 && (cyc[0] > cyc[1] ? cyc[0] - cyc[1] : cyc[1] - cyc[0]) <= 252, 1'b1);
        chk("two_only", cyc[2] + cyc[3], 0);
        conclude();
    end
endmodule
`default_nettype wire
